/* File: amos_pkg.sv */
// Constants, types and helper functions of the analog monitor output scaler
package amos_pkg;

	localparam int AMOS_ADDR_W = 4;
	localparam int AMOS_DATA_W = 16;
	localparam int AMOS_SRC_W = 24;
	localparam int AMOS_MV_W = 32;
	localparam int AMOS_CODE_W = 16;
	localparam int AMOS_PROD_W = 48;
	localparam int AMOS_WIDE_W = 64;

	// Register word offsets
	localparam logic [3:0] AMOS_SEL1_OFS = 4'h0;
	localparam logic [3:0] AMOS_SEL2_OFS = 4'h1;
	localparam logic [3:0] AMOS_OFF1_OFS = 4'h2;
	localparam logic [3:0] AMOS_OFF2_OFS = 4'h3;
	localparam logic [3:0] AMOS_MUL1_OFS = 4'h4;
	localparam logic [3:0] AMOS_MUL2_OFS = 4'h5;
	localparam logic [3:0] AMOS_STAT_OFS = 4'h6;
	localparam logic [3:0] AMOS_CODE1_OFS = 4'h7;
	localparam logic [3:0] AMOS_CODE2_OFS = 4'h8;
	localparam logic [3:0] AMOS_STATE_OFS = 4'h9;

	// Status bit positions
	localparam int AMOS_ST_RSV1_BIT = 0;
	localparam int AMOS_ST_RSV2_BIT = 1;
	localparam int AMOS_ST_SAT1_BIT = 2;
	localparam int AMOS_ST_SAT2_BIT = 3;

	// Selection codes
	localparam logic [3:0] AMOS_SEL_SPEED = 4'h0;
	localparam logic [3:0] AMOS_SEL_SPEED_REF = 4'h1;
	localparam logic [3:0] AMOS_SEL_FORCE_REF = 4'h2;
	localparam logic [3:0] AMOS_SEL_POS_ERR = 4'h3;
	localparam logic [3:0] AMOS_SEL_AMP_ERR = 4'h4;
	localparam logic [3:0] AMOS_SEL_POS_REF_SPD = 4'h5;
	localparam logic [3:0] AMOS_SEL_POS_DONE = 4'h8;
	localparam logic [3:0] AMOS_SEL_SPEED_FF = 4'h9;
	localparam logic [3:0] AMOS_SEL_FORCE_FF = 4'ha;
	localparam logic [3:0] AMOS_SEL_GAIN = 4'hb;
	localparam logic [3:0] AMOS_SEL_REF_DONE = 4'hc;

	// Reset values
	localparam logic [3:0] AMOS_SEL1_RST = AMOS_SEL_FORCE_REF;
	localparam logic [3:0] AMOS_SEL2_RST = AMOS_SEL_SPEED;
	localparam logic signed [15:0] AMOS_OFF_RST = 16'sh0000;
	localparam logic signed [15:0] AMOS_MUL_RST = 16'sh0064;

	// Setting limits, plus and minus 10000
	localparam logic signed [15:0] AMOS_SET_MAX = 16'sh2710;
	localparam logic signed [15:0] AMOS_SET_MIN = -16'sh2710;

	// Millivolt weights of the sources
	localparam logic signed [31:0] AMOS_ERR_MV = 32'sh0000_0032;
	localparam logic signed [31:0] AMOS_FLAG_MV = 32'sh0000_1388;
	localparam logic signed [31:0] AMOS_GAIN1_MV = 32'sh0000_03e8;
	localparam logic signed [31:0] AMOS_GAIN2_MV = 32'sh0000_07d0;

	// Multiplier step 0.01, offset step 0.1 V = 100 mV
	localparam logic signed [47:0] AMOS_MUL_DIV = 48'sh0000_0000_0064;
	localparam logic signed [47:0] AMOS_OFF_MV = 48'sh0000_0000_0064;

	// Code = mV * 3355 / 1024, about 32768 codes per 10 V
	localparam logic signed [63:0] AMOS_CODE_NUM = 64'sh0000_0000_0000_0d1b;
	localparam int AMOS_CODE_SHIFT = 10;
	localparam logic signed [63:0] AMOS_CODE_MAX = 64'sh0000_0000_0000_7fff;
	localparam logic signed [63:0] AMOS_CODE_MIN = -64'sh0000_0000_0000_8000;

	typedef enum logic [1:0] {AMOS_MODE_POS, AMOS_MODE_SPEED, AMOS_MODE_FORCE}
		amos_mode_t;

	function automatic logic signed [15:0] amos_clamp(
		input logic signed [15:0] v);
		if (v > AMOS_SET_MAX) return AMOS_SET_MAX;
		if (v < AMOS_SET_MIN) return AMOS_SET_MIN;
		return v;
	endfunction

	function automatic logic amos_reserved(input logic [3:0] s);
		return (s == 4'h6) || (s == 4'h7) || (s > AMOS_SEL_REF_DONE);
	endfunction

endpackage

/* File: amos_scale.sv */
// One monitor channel: multiply, add offset, negate, convert and saturate
module amos_scale
	import amos_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic signed [AMOS_MV_W-1:0] srcMv,
	input wire logic signed [15:0] mult,
	input wire logic signed [15:0] offset,
	output logic signed [AMOS_CODE_W-1:0] code,
	output logic satPulse
);

	logic signed [AMOS_PROD_W-1:0] prod_reg;
	logic signed [AMOS_PROD_W-1:0] off_reg;
	logic signed [AMOS_PROD_W-1:0] sumMv;
	logic signed [AMOS_WIDE_W-1:0] negMv;
	logic signed [AMOS_WIDE_W-1:0] rawCode;
	logic signed [AMOS_CODE_W-1:0] code_next;
	logic satHi;
	logic satLo;

	// Selected signal times multiplier, then plus offset, then times -1
	assign sumMv = prod_reg / AMOS_MUL_DIV + off_reg;
	assign negMv = -AMOS_WIDE_W'(sumMv);
	assign rawCode = (negMv * AMOS_CODE_NUM) >>> AMOS_CODE_SHIFT;
	assign satHi = rawCode > AMOS_CODE_MAX;
	assign satLo = rawCode < AMOS_CODE_MIN;
	assign code_next = satHi ? AMOS_CODE_W'(AMOS_CODE_MAX) :
		satLo ? AMOS_CODE_W'(AMOS_CODE_MIN) :
		AMOS_CODE_W'(rawCode);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prod_reg <= '0;
			off_reg <= '0;
			code <= '0;
			satPulse <= 1'b0;
		end else begin
			prod_reg <= AMOS_PROD_W'(srcMv) * AMOS_PROD_W'(mult);
			off_reg <= AMOS_PROD_W'(offset) * AMOS_OFF_MV;
			code <= code_next;
			satPulse <= satHi | satLo;
		end
	end

endmodule // amos_scale

/* File: amos_top.sv */
// Two-channel analog monitor output scaler with its register file
//
// Strobed register access and the placing of the registers are this design's own decisions.
module amos_top
	import amos_pkg::*;
#(
	parameter int CHANNELS = 2
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [AMOS_ADDR_W-1:0] regAddr,
	input wire logic [AMOS_DATA_W-1:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [AMOS_DATA_W-1:0] regRdData,
	input wire logic signed [AMOS_SRC_W-1:0] motorSpeed,
	input wire logic signed [AMOS_SRC_W-1:0] speedRef,
	input wire logic signed [AMOS_SRC_W-1:0] posRefSpeed,
	input wire logic signed [AMOS_SRC_W-1:0] speedFf,
	input wire logic signed [AMOS_SRC_W-1:0] forceRef,
	input wire logic signed [AMOS_SRC_W-1:0] forceFf,
	input wire logic signed [AMOS_SRC_W-1:0] posError,
	input wire logic signed [AMOS_SRC_W-1:0] posAmpError,
	input wire logic posDone,
	input wire logic posRefDone,
	input wire logic secondGain,
	input wire amos_mode_t ctrlMode,
	output logic signed [AMOS_CODE_W-1:0] monitorOneCode,
	output logic signed [AMOS_CODE_W-1:0] monitorTwoCode
);

	// Settings, one set per channel
	logic [3:0] selArr_reg [CHANNELS];
	logic signed [15:0] offArr_reg [CHANNELS];
	logic signed [15:0] mulArr_reg [CHANNELS];
	logic [3:0] status_reg;
	logic [3:0] status_next;
	logic [AMOS_DATA_W-1:0] rdData_next;

	// Per-channel results
	logic signed [AMOS_CODE_W-1:0] chCode [CHANNELS];
	logic [CHANNELS-1:0] chSat;
	logic [CHANNELS-1:0] chRsv;
	logic signed [AMOS_MV_W-1:0] chMv [CHANNELS];

	// Source table in millivolts, indexed by selection code
	logic signed [AMOS_MV_W-1:0] srcTable [16];
	logic posModeOn;
	logic signed [AMOS_MV_W-1:0] posErrMv;
	logic signed [AMOS_MV_W-1:0] ampErrMv;

	// Write decode
	logic wrSel1;
	logic wrSel2;
	logic wrOff1;
	logic wrOff2;
	logic wrMul1;
	logic wrMul2;
	logic wrStat;
	logic signed [15:0] wrClamped;
	logic [3:0] statClear;

	assign posModeOn = ctrlMode == AMOS_MODE_POS;
	assign posErrMv = posModeOn ?
		AMOS_MV_W'(posError) * AMOS_ERR_MV : '0;
	assign ampErrMv = AMOS_MV_W'(posAmpError) * AMOS_ERR_MV;

	// Speed in mm/s and force in 0.1 percent both map to 1 mV per count
	assign srcTable[0] = AMOS_MV_W'(motorSpeed);
	assign srcTable[1] = AMOS_MV_W'(speedRef);
	assign srcTable[2] = AMOS_MV_W'(forceRef);
	assign srcTable[3] = posErrMv;
	assign srcTable[4] = ampErrMv;
	assign srcTable[5] = AMOS_MV_W'(posRefSpeed);
	assign srcTable[6] = '0;
	assign srcTable[7] = '0;
	assign srcTable[8] = posDone ? AMOS_FLAG_MV : '0;
	assign srcTable[9] = AMOS_MV_W'(speedFf);
	assign srcTable[10] = AMOS_MV_W'(forceFf);
	assign srcTable[11] = secondGain ? AMOS_GAIN2_MV : AMOS_GAIN1_MV;
	assign srcTable[12] = posRefDone ? AMOS_FLAG_MV : '0;
	assign srcTable[13] = '0;
	assign srcTable[14] = '0;
	assign srcTable[15] = '0;

	assign wrSel1 = regWrStb && regAddr == AMOS_SEL1_OFS;
	assign wrSel2 = regWrStb && regAddr == AMOS_SEL2_OFS;
	assign wrOff1 = regWrStb && regAddr == AMOS_OFF1_OFS;
	assign wrOff2 = regWrStb && regAddr == AMOS_OFF2_OFS;
	assign wrMul1 = regWrStb && regAddr == AMOS_MUL1_OFS;
	assign wrMul2 = regWrStb && regAddr == AMOS_MUL2_OFS;
	assign wrStat = regWrStb && regAddr == AMOS_STAT_OFS;
	assign wrClamped = amos_clamp(regWrData);
	assign statClear = wrStat ? regWrData[3:0] : 4'h0;

	// Sticky status: hardware set wins over a write-one clear
	assign status_next = (status_reg & ~statClear) |
		{chSat[1], chSat[0], chRsv[1], chRsv[0]};

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			assign chRsv[ch] = amos_reserved(selArr_reg[ch]);
			assign chMv[ch] = srcTable[selArr_reg[ch]];

			amos_scale u_scale (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.srcMv(chMv[ch]),
				.mult(mulArr_reg[ch]),
				.offset(offArr_reg[ch]),
				.code(chCode[ch]),
				.satPulse(chSat[ch])
			);
		end
	endgenerate

	assign monitorOneCode = chCode[0];
	assign monitorTwoCode = chCode[1];

	// Read multiplexer, unmapped words read zero
	always_comb begin
		rdData_next = '0;
		unique case (regAddr)
			AMOS_SEL1_OFS: rdData_next = {12'h000, selArr_reg[0]};
			AMOS_SEL2_OFS: rdData_next = {12'h000, selArr_reg[1]};
			AMOS_OFF1_OFS: rdData_next = offArr_reg[0];
			AMOS_OFF2_OFS: rdData_next = offArr_reg[1];
			AMOS_MUL1_OFS: rdData_next = mulArr_reg[0];
			AMOS_MUL2_OFS: rdData_next = mulArr_reg[1];
			AMOS_STAT_OFS: rdData_next = {12'h000, status_reg};
			AMOS_CODE1_OFS: rdData_next = chCode[0];
			AMOS_CODE2_OFS: rdData_next = chCode[1];
			AMOS_STATE_OFS: rdData_next = {11'h000, secondGain,
				posRefDone, posDone, ctrlMode};
			default: rdData_next = '0;
		endcase
	end

	// Settings take effect on the cycle after the write
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			selArr_reg[0] <= AMOS_SEL1_RST;
			selArr_reg[1] <= AMOS_SEL2_RST;
			offArr_reg[0] <= AMOS_OFF_RST;
			offArr_reg[1] <= AMOS_OFF_RST;
			mulArr_reg[0] <= AMOS_MUL_RST;
			mulArr_reg[1] <= AMOS_MUL_RST;
		end else begin
			if (wrSel1) selArr_reg[0] <= regWrData[3:0];
			if (wrSel2) selArr_reg[1] <= regWrData[3:0];
			if (wrOff1) offArr_reg[0] <= wrClamped;
			if (wrOff2) offArr_reg[1] <= wrClamped;
			if (wrMul1) mulArr_reg[0] <= wrClamped;
			if (wrMul2) mulArr_reg[1] <= wrClamped;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			status_reg <= 4'h0;
			regRdData <= '0;
		end else begin
			status_reg <= status_next;
			regRdData <= regRdStb ? rdData_next : '0;
		end
	end

endmodule // amos_top

/* File: amos_top_props.sv */
// Assertion checker for the analog monitor output scaler
module amos_top_props
	import amos_pkg::*;
#(
	parameter int CHANNELS = 2
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [AMOS_ADDR_W-1:0] regAddr,
	input wire logic [AMOS_DATA_W-1:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [AMOS_DATA_W-1:0] regRdData,
	input wire logic posDone,
	input wire logic posRefDone,
	input wire amos_mode_t ctrlMode,
	input wire logic signed [AMOS_CODE_W-1:0] monitorOneCode,
	input wire logic signed [AMOS_CODE_W-1:0] monitorTwoCode
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] selOne_reg;
	logic [15:0] offOne_reg;
	// Shadow of channel one select and offset
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			selOne_reg <= AMOS_SEL1_RST;
			offOne_reg <= '0;
		end else if (regWrStb && regAddr == AMOS_SEL1_OFS) begin
			selOne_reg <= regWrData[3:0];
		end else if (regWrStb && regAddr == AMOS_OFF1_OFS) begin
			offOne_reg <= regWrData;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence sErrIdle;
		selOne_reg == AMOS_SEL_POS_ERR && offOne_reg == '0 &&
			ctrlMode != AMOS_MODE_POS;
	endsequence
	sequence sRsvIdle;
		selOne_reg inside {4'h6, 4'h7, [4'hd:4'hf]} && offOne_reg == '0;
	endsequence
	sequence sRefOpen;
		selOne_reg == AMOS_SEL_REF_DONE && offOne_reg == '0 && !posRefDone;
	endsequence
	a_reset_zero: assert property (disable iff (1'b0) !rst_n |=>
		monitorOneCode == '0 && monitorTwoCode == '0 && regRdData == '0)
		else $error("codes not cleared by reset");
	a_rd_idle: assert property (!$past(regRdStb) |-> regRdData == '0)
		else $error("read data outside read cycle");
	a_unmapped_zero: assert property (regRdStb && regAddr > AMOS_STATE_OFS
		|=> regRdData == '0) else $error("unmapped read not zero");
	a_sel_width: assert property (regRdStb && regAddr <= AMOS_SEL2_OFS
		|=> regRdData < 16'h0010) else $error("select wider than code");
	a_set_range: assert property (regRdStb &&
		regAddr inside {[AMOS_OFF1_OFS:AMOS_MUL2_OFS]} |=>
		$signed(regRdData) <= AMOS_SET_MAX &&
		$signed(regRdData) >= AMOS_SET_MIN) else $error("setting out of range");
	a_state_read: assert property (regRdStb && regAddr == AMOS_STATE_OFS
		|=> regRdData[2:0] == {$past(posDone), $past(ctrlMode)})
		else $error("state word wrong");
	a_pos_err_zero: assert property (sErrIdle [*3] |->
		monitorOneCode == '0) else $error("position error not zero");
	a_rsv_zero: assert property (sRsvIdle [*3] |->
		monitorOneCode == '0) else $error("reserved select not zero");
	a_flag_low: assert property (sRefOpen [*3] |->
		monitorOneCode == '0) else $error("open flag not zero");
endmodule // amos_top_props

bind amos_top amos_top_props #(.CHANNELS(CHANNELS)) u_props (
	.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
	.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
	.regRdData(regRdData), .posDone(posDone), .posRefDone(posRefDone),
	.ctrlMode(ctrlMode), .monitorOneCode(monitorOneCode),
	.monitorTwoCode(monitorTwoCode));

/* File: amos_recorder.sv */
// Recorder model that samples both monitor codes every cycle
module amos_recorder
	import amos_pkg::*;
(
	input wire logic ref_clk,
	input wire logic signed [AMOS_CODE_W-1:0] chanOne,
	input wire logic signed [AMOS_CODE_W-1:0] chanTwo,
	output logic signed [AMOS_CODE_W-1:0] sampleOne,
	output logic signed [AMOS_CODE_W-1:0] sampleTwo
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge ref_clk) begin
		sampleOne <= chanOne;
		sampleTwo <= chanTwo;
	end
endmodule // amos_recorder

/* File: analog_monitor_output_scaler_test.sv */
// Self-checking testbench for the analog monitor output scaler
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module analog_monitor_output_scaler_test
	import amos_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rst_n, regWrStb, regRdStb, posDone, posRefDone, secondGain;
	logic [3:0] regAddr;
	logic [15:0] regWrData, regRdData;
	logic signed [23:0] motorSpeed, speedRef, posRefSpeed, speedFf;
	logic signed [23:0] forceRef, forceFf, posError, posAmpError;
	amos_mode_t ctrlMode;
	logic signed [15:0] codeOne, codeTwo, sampleOne, sampleTwo;
	int n_fail = 0;
	int compares = 0;
	logic [3:0] selList [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8,
		4'h9, 4'ha, 4'hb, 4'hc};
	logic [3:0] flagSel [3] = '{4'hc, 4'h8, 4'hb};
	longint flagMv [3] = '{5000, 0, 1000};
	longint mvList [11] = '{1234, -2000, 500, 2000, -1500, 777, 5000, -99,
		300, 2000, 0};
	amos_top #(.CHANNELS(2)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
		.regRdStb(regRdStb), .regRdData(regRdData), .motorSpeed(motorSpeed),
		.speedRef(speedRef), .posRefSpeed(posRefSpeed), .speedFf(speedFf),
		.forceRef(forceRef), .forceFf(forceFf), .posError(posError),
		.posAmpError(posAmpError), .posDone(posDone), .posRefDone(posRefDone),
		.secondGain(secondGain), .ctrlMode(ctrlMode),
		.monitorOneCode(codeOne), .monitorTwoCode(codeTwo));
	amos_recorder rec (.ref_clk(ref_clk), .chanOne(codeOne),
		.chanTwo(codeTwo), .sampleOne(sampleOne), .sampleTwo(sampleTwo));
	function automatic logic [15:0] expCode(longint mv, longint mul, longint off);
		longint v;
		v = mv * mul / 100 + off * 100;
		v = (-v * 3355) >>> 10;
		if (v > 32767) v = 32767;
		if (v < -32768) v = -32768;
		return v[15:0];
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge ref_clk);
		regWrStb <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		#1 `CHK(regRdData, e)
	endtask
	task automatic settle;
		repeat (6) @(posedge ref_clk);
		#1;
	endtask
	task automatic wrap_up;
		$display("Mismatches %0d comparisons %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		n_fail++;
		wrap_up();
	end
	initial begin
		{rst_n, regWrStb, regRdStb, regAddr, regWrData} = '0;
		{motorSpeed, speedRef, forceRef, posError} = {24'sd1234, -24'sd2000,
			24'sd500, 24'sd40};
		{posAmpError, posRefSpeed, speedFf, forceFf} = {-24'sd30, 24'sd777,
			-24'sd99, 24'sd300};
		{posDone, posRefDone, secondGain} = 3'b101;
		ctrlMode = AMOS_MODE_POS;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(AMOS_SEL1_OFS, 16'h0002);
		rd(AMOS_SEL2_OFS, 16'h0000);
		rd(AMOS_OFF1_OFS, 16'h0000);
		rd(AMOS_MUL2_OFS, 16'h0064);
		rd(4'hf, 16'h0000);
		wr(AMOS_MUL2_OFS, 16'h00c8);
		wr(AMOS_OFF2_OFS, 16'h000a);
		for (int i = 0; i < 11; i++) begin
			wr(AMOS_SEL1_OFS, {12'h000, selList[i]});
			wr(AMOS_SEL2_OFS, {12'h000, selList[i]});
			settle();
			`CHK(sampleOne, expCode(mvList[i], 100, 0))
			`CHK(sampleTwo, expCode(mvList[i], 200, 10))
		end
		wr(AMOS_SEL1_OFS, 16'h0006);
		settle();
		`CHK(sampleOne, 16'h0000)
		@(posedge ref_clk);
		ctrlMode <= AMOS_MODE_SPEED;
		wr(AMOS_SEL1_OFS, 16'h0003);
		settle();
		`CHK(sampleOne, 16'h0000)
		rd(AMOS_STATE_OFS, 16'h0015);
		wr(AMOS_OFF1_OFS, 16'h4e20);
		rd(AMOS_OFF1_OFS, 16'h2710);
		wr(AMOS_MUL1_OFS, 16'hb1e0);
		rd(AMOS_MUL1_OFS, 16'hd8f0);
		settle();
		`CHK(sampleOne, expCode(0, -10000, 10000))
		wr(AMOS_OFF1_OFS, 16'hd8f0);
		settle();
		`CHK(sampleOne, expCode(0, -10000, -10000))
		rd(AMOS_CODE1_OFS, 16'h7fff);
		@(posedge ref_clk);
		{posDone, posRefDone, secondGain} <= 3'b010;
		wr(AMOS_MUL2_OFS, 16'h0064);
		for (int i = 0; i < 3; i++) begin
			wr(AMOS_SEL2_OFS, {12'h000, flagSel[i]});
			settle();
			`CHK(sampleTwo, expCode(flagMv[i], 100, 10))
		end
		rd(AMOS_CODE2_OFS, expCode(1000, 100, 10));
		rd(AMOS_STAT_OFS, 16'h000d);
		wr(AMOS_STAT_OFS, 16'h000f);
		rd(AMOS_STAT_OFS, 16'h0004);
		wrap_up();
	end
endmodule // analog_monitor_output_scaler_test
